// ### rtl/tge_map.vh
`ifndef TGE_MAP_VH
`define TGE_MAP_VH

// apb byte offsets
`define TGE_OFF_INSTR 8'h00
`define TGE_OFF_ADDR 8'h04
`define TGE_OFF_STAT 8'h08
`define TGE_OFF_COND 8'h0C
`define TGE_OFF_QUERY 8'h10
`define TGE_OFF_SWITCH 8'h14
`define TGE_OFF_MPTR 8'h18
`define TGE_OFF_MDATA 8'h1C
// general registers sit at 0x20..0x34, one word each, in select-bit order
`define TGE_GPR_HI 3'h1
`define TGE_GPR_LAST 3'h5
`define TGE_GPR_COUNT 6

// general register indices (also the bit number in a unitary select field)
`define TGE_IX_I 3'h0
`define TGE_IX_J 3'h1
`define TGE_IX_K 3'h2
`define TGE_IX_E 3'h3
`define TGE_IX_A 3'h4
`define TGE_IX_T 3'h5

// instruction fields
`define TGE_F_OP6 23:18
`define TGE_F_OP8 23:16
`define TGE_F_OP12 23:12
`define TGE_F_OP18 23:6
`define TGE_F_X 16:15
`define TGE_F_R 17:15
`define TGE_F_R1 11:6
`define TGE_F_R2 5:0
`define TGE_F_SHORT 14:0
`define TGE_F_LONG 15:0
`define TGE_F_BYTE 7:0
`define TGE_F_NIB 3:0
`define TGE_F_BSEL 23:22
`define TGE_F_IDX 15:0

// six-bit memory reference opcodes (octal 67 27 07 06 51 05 04 01 02 10 62)
`define TGE_OP_SWAPE 6'h37
`define TGE_OP_RBYTE 6'h17
`define TGE_OP_LBYTE 6'h07
`define TGE_OP_LDBL 6'h06
`define TGE_OP_LQRY 6'h29
`define TGE_OP_LA 6'h05
`define TGE_OP_LE 6'h04
`define TGE_OP_LI 6'h01
`define TGE_OP_LJ 6'h02
`define TGE_OP_LBLK 6'h08
`define TGE_OP_LSHORT 6'h32
// register opcodes (octal 0035 0036 0037 236 003100)
`define TGE_OP_XCHG 12'h01D
`define TGE_OP_LCOND 12'h01E
`define TGE_OP_LSBYTE 12'h01F
`define TGE_OP_LLONG 8'h9E
`define TGE_OP_SWCOPY 18'h0_0640

// byte select codes
`define TGE_BS_NONE 2'h0
`define TGE_BS_LEFT 2'h1
`define TGE_BS_MID 2'h2
`define TGE_BS_RIGHT 2'h3

// trap-query register
`define TGE_Q_MASK 24'hE3_FFFF
`define TGE_Q_DIS 23
`define TGE_Q_WRONLY 22
`define TGE_Q_USER 21
`define TGE_F_QADDR 17:0

// condition register bits
`define TGE_C_OVF 0
`define TGE_C_NEG 1
`define TGE_C_ZERO 2
`define TGE_C_POS 3

// executor states
`define TGE_ST_IDLE 2'h0
`define TGE_ST_DEC 2'h1
`define TGE_ST_RD 2'h2
`define TGE_ST_WAIT 2'h3

// multi-word steps, status bits, widths, constants
`define TGE_STEP_DBL 3'h1
`define TGE_STEP_BLK 3'h4
`define TGE_STEP_ZERO 3'h0
`define TGE_STAT_BUSY 4
`define TGE_ADDR_IND 24
`define TGE_MEM_AW 8
`define TGE_MEM_DEPTH 256
`define TGE_ZERO24 24'h00_0000
`define TGE_ZERO32 32'h0000_0000
`define TGE_ZERO4 4'h0
`define TGE_ONE8 8'h01

`endif

// ### rtl/tge_word_mem.v
`timescale 1ns/100ps
`include "tge_map.vh"
module tge_word_mem (
  input wire clk,
  input wire wrEn,
  input wire [`TGE_MEM_AW-1:0] addr,
  input wire [23:0] wrData,
  output reg [23:0] rdData
);
  reg [23:0] words [0:`TGE_MEM_DEPTH-1];

  // registered read; a write shows the old word on the same edge
  always @(posedge clk) begin
    if (wrEn) begin
      words[addr] <= wrData;
    end
    rdData <= words[addr];
  end
endmodule // tge_word_mem

// ### rtl/tge_executor.v
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "tge_map.vh"
module tge_executor (
  input wire clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [23:0] consoleSwitches,
  output wire busy,
  output wire trapEnable,
  output wire trapWriteOnly,
  output wire trapUserOnly,
  output wire [17:0] trapAddress
);
  // reset release synchroniser; the rest of the block uses rstN
  reg [1:0] rstSync_r;
  wire rstN;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstSync_r <= 2'h0;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rstN = rstSync_r[1];

  // console switches are asynchronous pins: two flops before use
  reg [23:0] swMeta_r;
  reg [23:0] sw_r;
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      swMeta_r <= `TGE_ZERO24;
      sw_r <= `TGE_ZERO24;
    end else begin
      swMeta_r <= consoleSwitches;
      sw_r <= swMeta_r;
    end
  end

  reg [23:0] gpr_r [0:`TGE_GPR_COUNT-1];
  reg [23:0] instr_r;
  reg [23:0] addrBase_r;
  reg addrInd_r;
  reg [3:0] cond_r;
  reg [23:0] query_r;
  reg [1:0] state_r;
  reg [2:0] step_r;
  reg [`TGE_MEM_AW-1:0] ptr_r;
  reg [`TGE_MEM_AW-1:0] memPtr_r;
  reg waitDone_r;
  wire [23:0] memRd;
  integer i;

  // or of every register whose select bit is set
  function [23:0] orSel;
    input [5:0] sel;
    input [143:0] flat;
    integer k;
    begin
      orSel = `TGE_ZERO24;
      for (k = 0; k < `TGE_GPR_COUNT; k = k + 1) begin
        orSel = orSel | (flat[k*24 +: 24] & {24{sel[k]}});
      end
    end
  endfunction

  // flags from sign and zero; overflow bit is left as it was
  function [3:0] flagsOf;
    input [3:0] old;
    input neg;
    input zero;
    begin
      flagsOf = {~neg & ~zero, zero, neg, old[`TGE_C_OVF]};
    end
  endfunction

  // three-bit register code of the short operand load to a select bit
  function [5:0] codeSel;
    input [2:0] code;
    begin
      case (code)
        3'h1: codeSel = 6'h01;
        3'h2: codeSel = 6'h02;
        3'h3: codeSel = 6'h04;
        3'h4: codeSel = 6'h08;
        3'h5: codeSel = 6'h10;
        3'h6: codeSel = 6'h20;
        default: codeSel = 6'h00;
      endcase
    end
  endfunction

  wire [143:0] gprFlat = {gpr_r[5], gpr_r[4], gpr_r[3], gpr_r[2], gpr_r[1], gpr_r[0]};
  // instruction decode
  wire [5:0] op6 = instr_r[`TGE_F_OP6];
  wire [11:0] op12 = instr_r[`TGE_F_OP12];
  wire isLong = instr_r[`TGE_F_OP8] == `TGE_OP_LLONG;
  wire isMemOp = !isLong && (op6 == `TGE_OP_SWAPE || op6 == `TGE_OP_LBYTE ||
    op6 == `TGE_OP_LDBL || op6 == `TGE_OP_LQRY || op6 == `TGE_OP_LA ||
    op6 == `TGE_OP_LE || op6 == `TGE_OP_LI || op6 == `TGE_OP_LJ ||
    op6 == `TGE_OP_LBLK);
  wire isByteRep = !isLong && op6 == `TGE_OP_RBYTE;
  wire [1:0] xSel = instr_r[`TGE_F_X];
  wire [23:0] xVal = (xSel == 2'h0) ? `TGE_ZERO24 : gpr_r[{1'b0, xSel - 2'h1}];

  // query load skips indexing unless reached through an indirect word
  wire useIdx = (op6 != `TGE_OP_LQRY) || addrInd_r;
  wire [23:0] effAddr = addrBase_r + (useIdx ? xVal : `TGE_ZERO24);
  // byte replace: final index ORed into I, then added to the address
  wire [23:0] repIdx = gpr_r[`TGE_IX_I] | xVal;
  wire [23:0] repAddr = addrBase_r + {8'h00, repIdx[`TGE_F_IDX]};
  wire [1:0] bSel = gpr_r[`TGE_IX_I][`TGE_F_BSEL];

  // merged word for byte replacement
  reg [23:0] merged;
  always @* begin
    merged = memRd;
    case (bSel)
      `TGE_BS_LEFT: merged[23:16] = gpr_r[`TGE_IX_A][7:0];
      `TGE_BS_MID: merged[15:8] = gpr_r[`TGE_IX_A][7:0];
      `TGE_BS_RIGHT: merged[7:0] = gpr_r[`TGE_IX_A][7:0];
      default: merged = memRd;
    endcase
  end

  // interchange operands, each side the or of its selected group
  wire [23:0] x1Val = orSel(instr_r[`TGE_F_R1], gprFlat);
  wire [23:0] x2Val = orSel(instr_r[`TGE_F_R2], gprFlat);
  wire [23:0] shortVal = {9'h000, instr_r[`TGE_F_SHORT]};
  wire [5:0] shortSel = codeSel(instr_r[`TGE_F_R]);
  wire [7:0] opByte = instr_r[`TGE_F_BYTE];

  // apb decode
  wire setup = psel & ~penable;
  wire access = psel & penable;
  assign busy = state_r != `TGE_ST_IDLE;
  wire inGpr = paddr[7:5] == `TGE_GPR_HI && paddr[4:2] <= `TGE_GPR_LAST;
  wire aligned = paddr[1:0] == 2'h0;
  wire isInstr = paddr == `TGE_OFF_INSTR;
  wire isAddr = paddr == `TGE_OFF_ADDR;
  wire isStat = paddr == `TGE_OFF_STAT;
  wire isCond = paddr == `TGE_OFF_COND;
  wire isQuery = paddr == `TGE_OFF_QUERY;
  wire isSwitch = paddr == `TGE_OFF_SWITCH;
  wire isMptr = paddr == `TGE_OFF_MPTR;
  wire isMdata = paddr == `TGE_OFF_MDATA;
  wire mapped = isInstr | isAddr | isStat | isCond | isQuery | isSwitch |
    isMptr | isMdata | (inGpr & aligned);
  wire readOnly = isStat | isQuery | isSwitch;
  // state that the executor owns may not be written while it runs
  wire bad = ~mapped | (pwrite & readOnly) | (busy & pwrite & ~isStat) |
    (busy & isMdata);
  // memory data read needs one wait state for the registered array
  wire mdRead = access & ~pwrite & isMdata & ~busy;
  assign pready = ~(mdRead & ~waitDone_r);
  assign pslverr = access & pready & bad;
  wire wrEn = access & pready & pwrite & ~bad;
  wire mdDone = access & pready & isMdata & ~bad;

  always @(posedge clk or negedge rstN) begin
    if (!rstN) waitDone_r <= 1'b0;
    else waitDone_r <= mdRead & ~waitDone_r;
  end

  // read data is captured in the setup cycle, or in the wait state
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      prdata <= `TGE_ZERO32;
    end else if (mdRead & ~waitDone_r) begin
      prdata <= {8'h00, memRd};
    end else if (setup & ~pwrite) begin
      if (inGpr & aligned) begin
        prdata <= {8'h00, gpr_r[paddr[4:2]]};
      end else if (isInstr) begin
        prdata <= {8'h00, instr_r};
      end else if (isAddr) begin
        prdata <= {7'h00, addrInd_r, addrBase_r};
      end else if (isStat) begin
        prdata <= {27'h000_0000, busy, cond_r};
      end else if (isCond) begin
        prdata <= {28'h000_0000, cond_r};
      end else if (isQuery) begin
        prdata <= {8'h00, query_r};
      end else if (isSwitch) begin
        prdata <= {8'h00, sw_r};
      end else if (isMptr) begin
        prdata <= {24'h00_0000, memPtr_r};
      end else begin
        prdata <= `TGE_ZERO32;
      end
    end
  end

  // memory port: software owns it while idle, the executor while busy
  wire fsmWe = state_r == `TGE_ST_WAIT && !isLong &&
    (op6 == `TGE_OP_SWAPE || op6 == `TGE_OP_RBYTE);
  wire [23:0] fsmWd = (op6 == `TGE_OP_SWAPE) ? gpr_r[`TGE_IX_E] : merged;
  wire memWe = busy ? fsmWe : (wrEn & isMdata);
  wire [`TGE_MEM_AW-1:0] memAddr = busy ? ptr_r : memPtr_r;
  wire [23:0] memWd = busy ? fsmWd : pwdata[23:0];

  tge_word_mem u_mem (
    .clk(clk),
    .wrEn(memWe),
    .addr(memAddr),
    .wrData(memWd),
    .rdData(memRd)
  );

  // trap controls follow the query register
  assign trapEnable = ~query_r[`TGE_Q_DIS];
  assign trapWriteOnly = query_r[`TGE_Q_WRONLY];
  assign trapUserOnly = query_r[`TGE_Q_USER];
  assign trapAddress = query_r[`TGE_F_QADDR];

  // executor and software-visible registers
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      for (i = 0; i < `TGE_GPR_COUNT; i = i + 1)
        gpr_r[i] <= `TGE_ZERO24;
      instr_r <= `TGE_ZERO24;
      addrBase_r <= `TGE_ZERO24;
      addrInd_r <= 1'b0;
      cond_r <= `TGE_ZERO4;
      query_r <= `TGE_ZERO24;
      state_r <= `TGE_ST_IDLE;
      step_r <= `TGE_STEP_ZERO;
      ptr_r <= {`TGE_MEM_AW{1'b0}};
      memPtr_r <= {`TGE_MEM_AW{1'b0}};
    end else begin
      // software writes only land while idle
      if (wrEn) begin
        if (inGpr) gpr_r[paddr[4:2]] <= pwdata[23:0];
        if (isAddr) begin
          addrBase_r <= pwdata[23:0];
          addrInd_r <= pwdata[`TGE_ADDR_IND];
        end
        if (isCond) cond_r <= pwdata[`TGE_F_NIB];
        if (isMptr) memPtr_r <= pwdata[`TGE_MEM_AW-1:0];
        if (isInstr) begin
          instr_r <= pwdata[23:0];
          state_r <= `TGE_ST_DEC;
        end
      end
      // the pointer steps after each data access so blocks stream in
      if (mdDone) memPtr_r <= memPtr_r + `TGE_ONE8;
      case (state_r)
        `TGE_ST_IDLE: step_r <= `TGE_STEP_ZERO;
        `TGE_ST_DEC: begin
          state_r <= `TGE_ST_IDLE;
          if (isLong) gpr_r[`TGE_IX_K] <= {8'h00, instr_r[`TGE_F_LONG]};
          else if (isMemOp) begin
            ptr_r <= effAddr[`TGE_MEM_AW-1:0];
            state_r <= `TGE_ST_RD;
          end else if (isByteRep) begin
            ptr_r <= repAddr[`TGE_MEM_AW-1:0];
            if (bSel != `TGE_BS_NONE) state_r <= `TGE_ST_RD;
          end else if (op6 == `TGE_OP_LSHORT) begin
            for (i = 0; i < `TGE_GPR_COUNT; i = i + 1) begin
              if (shortSel[i]) begin
                gpr_r[i] <= shortVal;
              end
            end
            cond_r <= flagsOf(cond_r, 1'b0, shortVal == `TGE_ZERO24);
          end else if (op12 == `TGE_OP_XCHG) begin
            // a register in both groups ends with the r2 result
            for (i = 0; i < `TGE_GPR_COUNT; i = i + 1) begin
              if (instr_r[i]) begin
                gpr_r[i] <= x1Val;
              end else if (instr_r[6 + i]) begin
                gpr_r[i] <= x2Val;
              end
            end
            cond_r <= flagsOf(cond_r, x1Val[23], x1Val == `TGE_ZERO24);
          end else if (op12 == `TGE_OP_LCOND) begin
            cond_r <= instr_r[`TGE_F_NIB];
          end else if (op12 == `TGE_OP_LSBYTE) begin
            gpr_r[`TGE_IX_A][7:0] <= opByte;
            cond_r <= flagsOf(cond_r, opByte[7], opByte == 8'h00);
          end else if (instr_r[`TGE_F_OP18] == `TGE_OP_SWCOPY) begin
            for (i = 0; i < `TGE_GPR_COUNT; i = i + 1) begin
              if (instr_r[i]) begin
                gpr_r[i] <= sw_r;
              end
            end
            cond_r <= flagsOf(cond_r, sw_r[23], sw_r == `TGE_ZERO24);
          end
        end
        `TGE_ST_RD: state_r <= `TGE_ST_WAIT;
        `TGE_ST_WAIT: begin
          state_r <= `TGE_ST_IDLE;
          case (op6)
            `TGE_OP_SWAPE: begin
              gpr_r[`TGE_IX_E] <= memRd;
              cond_r <= flagsOf(cond_r, memRd[23], memRd == `TGE_ZERO24);
            end
            `TGE_OP_LBYTE: begin
              gpr_r[`TGE_IX_A][7:0] <= memRd[7:0];
              cond_r <= flagsOf(cond_r, memRd[7], memRd[7:0] == 8'h00);
            end
            `TGE_OP_LDBL: begin
              if (step_r == `TGE_STEP_ZERO) begin
                gpr_r[`TGE_IX_E] <= memRd;
                ptr_r <= ptr_r + `TGE_ONE8;
                step_r <= `TGE_STEP_DBL;
                state_r <= `TGE_ST_RD;
              end else begin
                gpr_r[`TGE_IX_A] <= memRd;
                cond_r <= flagsOf(cond_r, gpr_r[`TGE_IX_E][23],
                  gpr_r[`TGE_IX_E] == `TGE_ZERO24 && memRd == `TGE_ZERO24);
              end
            end
            `TGE_OP_LQRY: query_r <= memRd & `TGE_Q_MASK;
            `TGE_OP_LA, `TGE_OP_LE, `TGE_OP_LI, `TGE_OP_LJ: begin
              case (op6)
                `TGE_OP_LA: gpr_r[`TGE_IX_A] <= memRd;
                `TGE_OP_LE: gpr_r[`TGE_IX_E] <= memRd;
                `TGE_OP_LI: gpr_r[`TGE_IX_I] <= memRd;
                default: gpr_r[`TGE_IX_J] <= memRd;
              endcase
              cond_r <= flagsOf(cond_r, memRd[23], memRd == `TGE_ZERO24);
            end
            `TGE_OP_LBLK: begin
              // step number is the register index: I J K E A
              gpr_r[step_r] <= memRd;
              if (step_r != `TGE_STEP_BLK) begin
                ptr_r <= ptr_r + `TGE_ONE8;
                step_r <= step_r + 3'h1;
                state_r <= `TGE_ST_RD;
              end
            end
            default: state_r <= `TGE_ST_IDLE;
          endcase
        end
        default: state_r <= `TGE_ST_IDLE;
      endcase
    end
  end
endmodule // tge_executor

// ### tb/tge_switch_panel.sv
`timescale 1ns/100ps
// console switch panel standing in front of the executor
module tge_switch_panel (
  input wire logic clk,
  input wire logic [23:0] setting,
  output logic [23:0] consoleSwitches
);
  // a set switch reads as one; the level only moves just after a clock edge
  initial consoleSwitches = 24'h00_0000;
  always @(posedge clk) begin
    consoleSwitches <= setting;
  end
endmodule // tge_switch_panel

// ### tb/tge_executor_sva.sv
`timescale 1ns/100ps
module tge_executor_sva (
  input wire clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [23:0] consoleSwitches,
  input wire busy,
  input wire trapEnable,
  input wire trapWriteOnly,
  input wire trapUserOnly,
  input wire [17:0] trapAddress
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // memory window read from idle: setup, one wait, then the answer
  sequence memRdSetup;
    psel && !penable && !pwrite && paddr == 8'h1C && !busy;
  endsequence
  sequence oneWait;
    !pready ##1 pready;
  endsequence
  memrd_wait_a: assert property (memRdSetup ##1 penable |-> oneWait)
    else $error("memory read wait state wrong");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  no_wait_a: assert property (psel && penable && paddr != 8'h1C |-> pready)
    else $error("unexpected wait state");
  busy_write_a: assert property (psel && penable && pwrite && busy |-> pslverr)
    else $error("write accepted while busy");
  unmapped_access_a: assert property (psel && penable && paddr >= 8'h38 |-> pslverr)
    else $error("unmapped access accepted");
  ro_write_a: assert property (psel && penable && pwrite &&
    (paddr == 8'h08 || paddr == 8'h10 || paddr == 8'h14) |-> pslverr)
    else $error("read-only write accepted");
  start_busy_a: assert property (psel && penable && pready && !pslverr && pwrite &&
    paddr == 8'h00 |=> busy)
    else $error("instruction did not start");
  busy_bound_a: assert property ($rose(busy) |-> ##[1:12] !busy)
    else $error("instruction runs too long");
  query_hold_a: assert property ($changed({trapEnable, trapWriteOnly, trapUserOnly,
    trapAddress}) |-> $past(busy))
    else $error("trap outputs moved outside an instruction");
endmodule // tge_executor_sva

bind tge_executor tge_executor_sva tge_executor_sva_i (.clk(clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .consoleSwitches(consoleSwitches), .busy(busy),
  .trapEnable(trapEnable), .trapWriteOnly(trapWriteOnly), .trapUserOnly(trapUserOnly),
  .trapAddress(trapAddress));

// ### tb/testbench.sv
`timescale 1ns/100ps
`include "tge_map.vh"
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin errorCnt++; \
  $display("[ERR] %0t mismatch got %h exp %h", $time, (g), (e)); end end
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [23:0] swSet = 24'hA5_5A5A;
  wire [31:0] prdata;
  wire pready, pslverr, busy, trapEnable, trapWriteOnly, trapUserOnly;
  wire [17:0] trapAddress;
  wire [23:0] consoleSwitches;
  int errorCnt = 0;
  int checksDone = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic err;
  localparam logic [5:0] LD_OP [4] = '{`TGE_OP_LA, `TGE_OP_LE, `TGE_OP_LI, `TGE_OP_LJ};
  localparam logic [7:0] LD_REG [4] = '{8'h30, 8'h2C, 8'h20, 8'h24};
  localparam logic [23:0] BYTE_EXP [4] = '{24'h12_3456, 24'h9A_3456, 24'h12_9A56,
    24'h12_349A};

  tge_executor tge_executor_i (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .consoleSwitches(consoleSwitches), .busy(busy),
    .trapEnable(trapEnable), .trapWriteOnly(trapWriteOnly), .trapUserOnly(trapUserOnly),
    .trapAddress(trapAddress));
  tge_switch_panel tge_switch_panel_i (.clk(clk), .setting(swSet),
    .consoleSwitches(consoleSwitches));

  // 100 ns period
  always #50 clk = ~clk;

  // hang guard, far above the six hundred or so cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errorCnt++;
      endOfTest();
    end
  end

  task automatic endOfTest();
    if (errorCnt == 0 && checksDone > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // one apb transfer; a gap edge after release keeps drivers from double assigning
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // only the hang guard ends a wait for the answer
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    apb(1'b1, a, {8'h00, d});
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [23:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, {8'h00, e})
  endtask
  task automatic condChk(input logic [3:0] e);
    apb(1'b0, 8'h08, 32'h0000_0000);
    `CHK(rd[3:0], e)
  endtask
  task automatic memPut(input logic [7:0] a, input logic [23:0] d);
    wr(8'h18, {16'h0000, a});
    wr(8'h1C, d);
  endtask
  task automatic waitIdle();
    rd = 32'h0000_0010;
    while (rd[4] !== 1'b0) begin
      apb(1'b0, 8'h08, 32'h0000_0000);
    end
  endtask
  task automatic exec(input logic [23:0] ins);
    wr(8'h00, ins);
    waitIdle();
  endtask

  task automatic testLoads();
    memPut(8'h10, 24'h80_0001);
    memPut(8'h11, 24'h12_3456);
    memPut(8'h12, 24'h00_0000);
    wr(8'h04, 24'h00_0010);
    for (int k = 0; k < 4; k++) begin
      exec({LD_OP[k], 18'h0_0000});
      rdChk(LD_REG[k], 24'h80_0001);
      condChk(4'h2);
    end
    wr(8'h04, 24'h00_0012);
    exec({`TGE_OP_LA, 18'h0_0000});
    condChk(4'h4);
  endtask

  task automatic testDouble();
    wr(8'h04, 24'h00_0010);
    exec({`TGE_OP_LDBL, 18'h0_0000});
    rdChk(8'h2C, 24'h80_0001);
    rdChk(8'h30, 24'h12_3456);
    condChk(4'h2);
    wr(8'h30, 24'hAB_CD00);
    wr(8'h04, 24'h00_0011);
    exec({`TGE_OP_LBYTE, 18'h0_0000});
    rdChk(8'h30, 24'hAB_CD56);
    condChk(4'h8);
    exec({`TGE_OP_LSBYTE, 4'h0, 8'h80});
    rdChk(8'h30, 24'hAB_CD80);
    condChk(4'h2);
  endtask

  task automatic testSwap();
    wr(8'h2C, 24'h00_0005);
    exec({`TGE_OP_SWAPE, 18'h0_0000});
    rdChk(8'h2C, 24'h12_3456);
    condChk(4'h8);
    wr(8'h18, 24'h00_0011);
    rdChk(8'h1C, 24'h00_0005);
  endtask

  task automatic testXchg();
    wr(8'h20, 24'h00_0001);
    wr(8'h24, 24'h00_0002);
    wr(8'h28, 24'h00_0004);
    exec({`TGE_OP_XCHG, 6'h01, 6'h02});
    rdChk(8'h20, 24'h00_0002);
    rdChk(8'h24, 24'h00_0001);
    exec({`TGE_OP_XCHG, 6'h03, 6'h04});
    rdChk(8'h28, 24'h00_0003);
    rdChk(8'h20, 24'h00_0004);
    rdChk(8'h24, 24'h00_0004);
    condChk(4'h8);
    exec({`TGE_OP_XCHG, 6'h00, 6'h00});
    rdChk(8'h28, 24'h00_0003);
  endtask

  task automatic testByte();
    wr(8'h30, 24'h00_009A);
    wr(8'h04, 24'h00_0010);
    for (int k = 0; k < 4; k++) begin
      memPut(8'h11, 24'h12_3456);
      wr(8'h20, {k[1:0], 22'h00_0001});
      exec({`TGE_OP_RBYTE, 18'h0_0000});
      wr(8'h18, 24'h00_0011);
      rdChk(8'h1C, BYTE_EXP[k]);
    end
    // I=1 and J=3: an OR gives word 0x13, an add would give 0x14
    wr(8'h24, 24'h00_0003);
    memPut(8'h13, 24'h12_3456);
    exec({`TGE_OP_RBYTE, 1'b0, 2'h2, 15'h0000});
    wr(8'h18, 24'h00_0013);
    rdChk(8'h1C, 24'h12_349A);
  endtask

  task automatic testQuery();
    memPut(8'h30, 24'hFF_FFFF);
    memPut(8'h31, 24'hFF_FFFF);
    wr(8'h04, 24'h00_0030);
    exec({`TGE_OP_LQRY, 18'h0_0000});
    rdChk(8'h10, 24'hE3_FFFF);
    `CHK({trapEnable, trapWriteOnly, trapUserOnly, trapAddress}, {3'b011, 18'h3_FFFF})
    memPut(8'h30, 24'h00_0000);
    wr(8'h20, 24'h00_0001);
    exec({`TGE_OP_LQRY, 1'b0, 2'h1, 15'h0000});
    `CHK({trapEnable, trapWriteOnly, trapUserOnly, trapAddress}, {3'b100, 18'h0_0000})
    // reached through an indirect word the index applies again: word 0x31
    apb(1'b1, 8'h04, 32'h0100_0030);
    exec({`TGE_OP_LQRY, 1'b0, 2'h1, 15'h0000});
    `CHK({trapEnable, trapWriteOnly, trapUserOnly, trapAddress}, {3'b011, 18'h3_FFFF})
  endtask

  task automatic testOps();
    wr(8'h30, 24'hFF_FFFF);
    exec({`TGE_OP_LSHORT, 3'h5, 15'h7FFF});
    rdChk(8'h30, 24'h00_7FFF);
    condChk(4'h8);
    wr(8'h28, 24'hFF_FFFF);
    exec({`TGE_OP_LLONG, 16'h8001});
    rdChk(8'h28, 24'h00_8001);
    exec({`TGE_OP_SWCOPY, 6'h18});
    rdChk(8'h2C, 24'hA5_5A5A);
    rdChk(8'h30, 24'hA5_5A5A);
    condChk(4'h2);
    for (int k = 0; k < 5; k++) memPut(8'(32 + k), 24'(k + 1));
    wr(8'h04, 24'h00_0020);
    exec({`TGE_OP_LBLK, 18'h0_0000});
    for (int k = 0; k < 5; k++) rdChk(8'(32 + 4 * k), 24'(k + 1));
    exec({`TGE_OP_LCOND, 8'h00, 4'h9});
    condChk(4'h9);
  endtask

  // refusals: unmapped place, read-only place, and a write while an instruction runs
  task automatic testRefuse();
    apb(1'b0, 8'h40, 32'h0000_0000);
    `CHK(err, 1'b1)
    apb(1'b1, 8'h08, 32'h0000_001F);
    `CHK(err, 1'b1)
    wr(8'h00, {`TGE_OP_LBLK, 18'h0_0000});
    apb(1'b1, 8'h30, 32'h0000_0077);
    `CHK(err, 1'b1)
    waitIdle();
    rdChk(8'h30, 24'h00_0005);
    condChk(4'h9);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(trapEnable, 1'b1)
    testLoads();
    testDouble();
    testSwap();
    testXchg();
    testByte();
    testQuery();
    testOps();
    testRefuse();
    endOfTest();
  end
endmodule // testbench
